// File: verilog/link_credit_event_monitor_regs.svh
// Register offsets, field positions, reset values and event codes of the credit monitor
`ifndef LINK_CREDIT_EVENT_MONITOR_REGS_SVH
`define LINK_CREDIT_EVENT_MONITOR_REGS_SVH

`define LCM_OFF_CTRL0        8'h00
`define LCM_OFF_CTRL1        8'h04
`define LCM_OFF_COUNT0       8'h08
`define LCM_OFF_COUNT1       8'h0c
`define LCM_OFF_COUNT_CTRL   8'h10
`define LCM_OFF_STATUS       8'h14

`define LCM_EVSEL_LSB        0
`define LCM_EVSEL_MSB        7
`define LCM_UMASK_LSB        8
`define LCM_UMASK_MSB        15
`define LCM_ENABLE_BIT       22

`define LCM_STAT_UNSUP0_BIT  0
`define LCM_STAT_UNSUP1_BIT  1

`define LCM_CTRL_RESET       32'h0000_0000
`define LCM_COUNT_RESET      48'h0000_0000_0000

`define LCM_EV_RESERVED_REJECT  8'h39
`define LCM_EV_RESERVED_USED    8'h38
`define LCM_EV_SHARED_ACQUIRE   8'h33

`define LCM_MAX_INC_SHARED   3'h4
`define LCM_MAX_INC_RESERVED 3'h1

`endif

// File: verilog/link_credit_event_monitor_pkg.sv
// Types shared by the link credit event monitor
package link_credit_event_monitor_pkg;

    // Message class bit positions within the unit mask
    typedef enum logic [2:0] {
        home_class                  = 3'h0,
        snoop_class                 = 3'h1,
        nondata_response_class      = 3'h2,
        data_response_class         = 3'h3,
        noncoherent_broadcast_class = 3'h4,
        noncoherent_standard_class  = 3'h5
    } msg_class_type;

    // Strobes from the transmit credit logic, one cycle each
    typedef struct packed {
        logic       shared_attempt;
        logic [5:0] shared_attempt_class;
        logic       shared_grant;
        logic [2:0] shared_grant_flits;
        logic       reserved_grant;
        logic [5:0] reserved_grant_class;
        logic       reserved_reject;
        logic [5:0] reserved_reject_class;
    } credit_events_type;

    // Decoded event selection of one counter
    typedef enum logic [1:0] {
        sel_none            = 2'b00,
        sel_reserved_reject = 2'b01,
        sel_reserved_used   = 2'b10,
        sel_shared_acquire  = 2'b11
    } event_sel_type;

endpackage : link_credit_event_monitor_pkg

// File: verilog/link_credit_event_monitor.sv
// Credit pool event selection and counting with a Wishbone register slave
//
// What this block does
// RULE_01: Code 0x39 counts requests delayed without credits
// RULE_02: Code 0x38 counts reserved credits on data-response
// RULE_03: Reserved grant adds one regardless of buffers
// RULE_04: Shared grant consumes one credit per buffer
// RULE_05: Code 0x33 adds shared credits, up to four
// RULE_06: Reserved events add at most one per cycle
// RULE_07: Credit events count only on counters zero, one
// RULE_08: Unit mask bits 15:8 select message classes
// RULE_09: Shared acquisition ignores message class filtering
// RULE_10: Shared pool tried first, reserved as fallback
// RULE_11: Several selected classes combine as logical OR
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "link_credit_event_monitor_regs.svh"

module link_credit_event_monitor #(
    parameter int COUNT_WIDTH = 48,
    parameter int NUM_COUNTERS = 2
) (
    // Clock and reset
    input  wire logic                                       core_clk,
    input  wire logic                                       reset_n,
    // Credit event strobes
    input  wire link_credit_event_monitor_pkg::credit_events_type events,
    // Wishbone slave
    input  wire logic                                       wb_cyc_i,
    input  wire logic                                       wb_stb_i,
    input  wire logic                                       wb_we_i,
    input  wire logic [7:0]                                 wb_adr_i,
    input  wire logic [3:0]                                 wb_sel_i,
    input  wire logic [31:0]                                wb_dat_i,
    output logic      [31:0]                                wb_dat_o,
    output logic                                            wb_ack_o,
    output logic                                            wb_err_o
);
    import link_credit_event_monitor_pkg::*;

    // The high-word register carries 16 bits per counter, so wider counters cannot be read
    generate
        if (COUNT_WIDTH < 33 || COUNT_WIDTH > 48) begin : g_bad_width
            $error("COUNT_WIDTH must lie between 33 and 48");
        end
        if (NUM_COUNTERS != 2) begin : g_bad_count
            $error("Credit events exist on exactly two counters");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic [31:0]            ctrl_q [NUM_COUNTERS];
    logic [COUNT_WIDTH-1:0] count_q [NUM_COUNTERS];
    logic [1:0]             unsup_q;
    logic                   req;
    logic                   hit;
    logic                   wr;
    logic [31:0]            rd_d;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;

    always_comb begin
        hit  = 1'b1;
        rd_d = 32'h0000_0000;
        case (wb_adr_i)
            `LCM_OFF_CTRL0: begin
                rd_d = ctrl_q[0];
            end
            `LCM_OFF_CTRL1: begin
                rd_d = ctrl_q[1];
            end
            `LCM_OFF_COUNT0: begin
                rd_d = count_q[0][31:0];
            end
            `LCM_OFF_COUNT1: begin
                rd_d = count_q[1][31:0];
            end
            `LCM_OFF_COUNT_CTRL: begin
                rd_d[15:0]  = 16'(count_q[0] >> 32);
                rd_d[31:16] = 16'(count_q[1] >> 32);
            end
            `LCM_OFF_STATUS: begin
                rd_d = {30'h0000_0000, unsup_q};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    assign wr = req & hit & wb_we_i;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
            wb_dat_o <= (req & hit & ~wb_we_i) ? rd_d : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event computation shared by both counters

    logic       reserved_reject_any;
    logic [5:0] reject_cls;
    logic [5:0] used_cls;
    logic [2:0] shared_inc;

    // Reject means neither shared nor reserved credit was available [RULE_10]
    assign reject_cls = events.reserved_reject ? events.reserved_reject_class : 6'h00;
    assign reserved_reject_any = events.reserved_reject & events.shared_attempt; // [RULE_10]
    // One use per reserved grant, buffers ignored [RULE_03]
    assign used_cls = events.reserved_grant ? events.reserved_grant_class : 6'h00;
    // Shared grant counts one credit per flit buffer, saturated at four [RULE_04] [RULE_05]
    assign shared_inc = !events.shared_grant ? 3'h0 :
                        (events.shared_grant_flits > `LCM_MAX_INC_SHARED) ?
                        `LCM_MAX_INC_SHARED : events.shared_grant_flits;

    ////////////////////////////////////////////////////////////////////////////
    // Counters

    genvar gi;
    generate
        for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_ctr
            event_sel_type sel;
            logic [7:0]    umask;
            logic          hit_r;
            logic          hit_u;
            logic [2:0]    inc;

            assign umask = ctrl_q[gi][`LCM_UMASK_MSB:`LCM_UMASK_LSB]; // [RULE_08]

            always_comb begin
                case (ctrl_q[gi][`LCM_EVSEL_MSB:`LCM_EVSEL_LSB])
                    `LCM_EV_RESERVED_REJECT: begin
                        sel = sel_reserved_reject;
                    end
                    `LCM_EV_RESERVED_USED: begin
                        sel = sel_reserved_used;
                    end
                    `LCM_EV_SHARED_ACQUIRE: begin
                        sel = sel_shared_acquire;
                    end
                    default: begin
                        sel = sel_none;
                    end
                endcase
            end

            // Any selected class counts [RULE_08] [RULE_11]
            assign hit_r = reserved_reject_any & |(reject_cls & umask[5:0]);
            // Used event is the data-response channel only [RULE_02]
            assign hit_u = |(used_cls & umask[5:0] &
                             (6'h01 << data_response_class));

            always_comb begin
                case (sel)
                    sel_reserved_reject: begin
                        inc = hit_r ? `LCM_MAX_INC_RESERVED : 3'h0; // [RULE_01] [RULE_06]
                    end
                    sel_reserved_used: begin
                        inc = hit_u ? `LCM_MAX_INC_RESERVED : 3'h0; // [RULE_02] [RULE_06]
                    end
                    sel_shared_acquire: begin
                        inc = shared_inc; // [RULE_05] [RULE_09]
                    end
                    default: begin
                        inc = 3'h0;
                    end
                endcase
            end

            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    ctrl_q[gi] <= `LCM_CTRL_RESET;
                end else if (wr && wb_adr_i == (gi == 0 ? `LCM_OFF_CTRL0 : `LCM_OFF_CTRL1)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            ctrl_q[gi][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                        end
                    end
                end
            end

            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    count_q[gi] <= COUNT_WIDTH'(`LCM_COUNT_RESET);
                end else if (wr && wb_adr_i == (gi == 0 ? `LCM_OFF_COUNT0 : `LCM_OFF_COUNT1)) begin
                    count_q[gi] <= COUNT_WIDTH'(wb_dat_i);
                end else if (ctrl_q[gi][`LCM_ENABLE_BIT]) begin
                    count_q[gi] <= count_q[gi] + COUNT_WIDTH'(inc); // [RULE_07]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Unsupported-selection status: a nonzero event code other than
    // the three credit events in a counter control marks that counter

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            unsup_q <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (g_ctr[0].sel == sel_none && c == 0) begin
                    unsup_q[c] <= ctrl_q[0][`LCM_EVSEL_MSB:`LCM_EVSEL_LSB] != 8'h00;
                end else if (g_ctr[1].sel == sel_none && c == 1) begin
                    unsup_q[c] <= ctrl_q[1][`LCM_EVSEL_MSB:`LCM_EVSEL_LSB] != 8'h00;
                end else begin
                    unsup_q[c] <= 1'b0;
                end
            end
        end
    end

endmodule : link_credit_event_monitor

// File: bench/link_credit_event_monitor_asserts.sv
// Wishbone answer checks for the credit monitor
`timescale 1ns/1ps
module link_credit_event_monitor_asserts (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // Wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    answer_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        |=> wb_ack_o ^ wb_err_o) else $error("no answer");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    err_pulse_a: assert property (wb_err_o |=> !wb_err_o) else $error("err held");
    answer_excl_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
    answer_cause_a: assert property (wb_ack_o || wb_err_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("answer without request");
    data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
    ack_mapped_a: assert property (wb_ack_o |-> $past(wb_adr_i) <= 8'h14
        && $past(wb_adr_i[1:0]) == 2'b00) else $error("ack on unmapped address");
    err_unmapped_a: assert property (wb_err_o |-> $past(wb_adr_i) > 8'h14
        || $past(wb_adr_i[1:0]) != 2'b00) else $error("err on mapped address");
    reset_quiet_a: assert property ($rose(reset_n) |-> !wb_ack_o && !wb_err_o)
        else $error("answer after reset");
endmodule : link_credit_event_monitor_asserts

bind link_credit_event_monitor link_credit_event_monitor_asserts asserts_u (
    .core_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o);

// File: bench/credit_source_model.sv
// Behavioural transmit credit logic raising one request per call
`timescale 1ns/1ps
module credit_source_model (
    // Clock
    input wire logic                                       core_clk,
    // Event strobes
    output link_credit_event_monitor_pkg::credit_events_type events
);
    import link_credit_event_monitor_pkg::*;
    initial events = '0;
    task automatic request(input logic [5:0] cls, input logic [2:0] flits,
                           input logic shared_ok, input logic reserved_ok);
        credit_events_type ev;
        ev = '0;
        ev.shared_attempt = 1'b1;
        ev.shared_attempt_class = cls;
        ev.shared_grant = shared_ok;
        ev.shared_grant_flits = shared_ok ? flits : 3'h0;
        ev.reserved_grant = !shared_ok && reserved_ok;
        ev.reserved_grant_class = ev.reserved_grant ? cls : 6'h00;
        ev.reserved_reject = !shared_ok && !reserved_ok;
        ev.reserved_reject_class = ev.reserved_reject ? cls : 6'h00;
        @(posedge core_clk);
        events <= ev;
        @(posedge core_clk);
        events <= '0;
    endtask : request
endmodule : credit_source_model

// File: bench/link_credit_event_monitor_tb_top.sv
// Self-checking bench for the link credit event monitor
`timescale 1ns/1ps
module link_credit_event_monitor_tb_top;
    import link_credit_event_monitor_pkg::*;
    logic              core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, er;
    logic [7:0]        wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [31:0]       wb_dat_i, wb_dat_o, rd;
    credit_events_type events;
    int                fail_count = 0, compares = 0, cycles = 0;

    link_credit_event_monitor dut_u (.core_clk, .reset_n, .events, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o);
    credit_source_model partner_u (.core_clk, .events);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [47:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 16);
        rd = wb_dat_o;
        er = wb_err_o;
        check("answer", {47'h0, n < 16}, 48'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    task automatic print_verdict();
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_reset();
        wb(1'b0, 8'h00, 32'h0);
        check("ctrl0 reset", rd, 48'h0);
        wb(1'b0, 8'h08, 32'h0);
        check("count0 reset", rd, 48'h0);
        wb(1'b1, 8'h18, 32'h1);
        check("unmapped err", er, 48'h1);
    endtask : check_reset

    // Home and non-coherent standard selected, every class rejected once, then both at once
    task automatic check_reject();
        wb(1'b1, 8'h00, 32'h0040_2139);
        for (int c = 0; c < 6; c++) partner_u.request(6'h01 << c, 3'h1, 1'b0, 1'b0);
        partner_u.request(6'h21, 3'h1, 1'b0, 1'b0);
        partner_u.request(6'h01, 3'h2, 1'b1, 1'b0);
        partner_u.request(6'h20, 3'h2, 1'b0, 1'b1);
        wb(1'b0, 8'h08, 32'h0);
        check("reject count", rd, 48'h3);
    endtask : check_reject

    // Multi-buffer reserved grants add one each; other classes and pools ignored
    task automatic check_used();
        wb(1'b1, 8'h04, 32'h0040_0838);
        partner_u.request(6'h08, 3'h7, 1'b0, 1'b1);
        partner_u.request(6'h08, 3'h7, 1'b0, 1'b1);
        partner_u.request(6'h04, 3'h1, 1'b0, 1'b1);
        partner_u.request(6'h08, 3'h2, 1'b1, 1'b0);
        partner_u.request(6'h08, 3'h1, 1'b0, 1'b0);
        wb(1'b0, 8'h0c, 32'h0);
        check("used count", rd, 48'h2);
    endtask : check_used

    // Preloaded counter gains 3, capped 4 and 1 from any class; carry into the high word
    task automatic check_shared();
        wb(1'b1, 8'h00, 32'h0040_0033);
        wb(1'b1, 8'h08, 32'h0000_0005);
        partner_u.request(6'h02, 3'h3, 1'b1, 1'b0);
        partner_u.request(6'h20, 3'h7, 1'b1, 1'b0);
        partner_u.request(6'h01, 3'h1, 1'b1, 1'b0);
        partner_u.request(6'h08, 3'h4, 1'b0, 1'b1);
        wb(1'b0, 8'h08, 32'h0);
        check("shared count", rd, 48'hd);
        wb(1'b0, 8'h0c, 32'h0);
        check("used count multi", rd, 48'h3);
        wb(1'b1, 8'h08, 32'hffff_fffe);
        partner_u.request(6'h04, 3'h3, 1'b1, 1'b0);
        wb(1'b0, 8'h08, 32'h0);
        check("shared count low", rd, 48'h1);
        wb(1'b0, 8'h10, 32'h0);
        check("count high words", rd, 48'h1);
        wb(1'b1, 8'h04, 32'h0040_0055);
        wb(1'b0, 8'h14, 32'h0);
        check("unsupported status", rd, 48'h2);
    endtask : check_shared

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        reset_n  = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        check_reset();
        check_reject();
        check_used();
        check_shared();
        print_verdict();
    end
endmodule : link_credit_event_monitor_tb_top
